// file: urx_consts.vh
`ifndef URX_CONSTS_VH
`define URX_CONSTS_VH

// Samples per bit in each speed mode.
`define URX_SPB_NORMAL 5'h10
`define URX_SPB_DOUBLE 5'h08
// First centre sample of a bit, numbered from one.
`define URX_VOTE_FIRST_NORMAL 5'h08
`define URX_VOTE_FIRST_DOUBLE 5'h04
// Data-plus-parity bit count limits.
`define URX_DBITS_MIN 4'h5
`define URX_DBITS_MAX 4'h0a
`define URX_DWIDTH 10
// Sequencer states.
`define URX_ST_IDLE 2'h0
`define URX_ST_START 2'h1
`define URX_ST_DATA 2'h2
`define URX_ST_STOP 2'h3

`endif

// file: urx_sync.v
`timescale 1ns/100ps
`default_nettype none

// Two-flop synchroniser; the first stage feeds only the second.
module urx_sync (
    input wire mclk,
    input wire reset_n,
    input wire clk_en,
    input wire din,
    output wire dout
);
    reg meta_ff;
    reg sync_ff;

    // The line idles high, so both stages reset high.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else if (clk_en) begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule // urx_sync

`default_nettype wire

// file: urx_recovery.v
// Behaviour
// - The serial input is sampled on every sample tick, a tick being 16 per bit normally and 8 per bit in double speed.
// - When idle the block watches for a high-to-low change and then starts start-bit validation.
// - With the first low sample as sample one, samples 8,9,10 (normal) or 4,5,6 (double) validate the start bit.
// - If two or more validation samples are high the start is dropped as noise and the search resumes.
// - A valid start bit realigns the bit timing and starts data recovery, anew for every frame.
// - A per-bit sequencer has one state per sample, 16 states normally and 8 in double speed.
// - Each bit is the majority of its three centre samples.
// - Recovery runs through data, optional parity and the first stop bit, and further stop bits are ignored.
// - The stop bit is voted the same way and a zero stop bit sets the frame error flag for that frame.
// - In normal mode a new falling edge is accepted right after the last stop voting sample, later in double speed.
`timescale 1ns/100ps
`default_nettype none
`include "urx_consts.vh"

module urx_recovery (
    input wire mclk,
    input wire reset_n,
    input wire clk_en,
    input wire rx_serial,
    input wire sample_tick,
    input wire double_speed_select,
    input wire [3:0] frame_bits,
    output reg [9:0] rx_data_ff,
    output reg frame_error_flag_ff,
    output reg rx_valid_ff,
    output wire rx_busy
);
    ////////////////////////////////////////////////////////////////////////
    // Majority of three samples, used for start, data and stop bits.
    function maj3;
        input [2:0] s;
        begin
            maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
        end
    endfunction

    // Clamp the configured bit count into the legal five to ten range.
    function [3:0] clamp_bits;
        input [3:0] n;
        begin
            if (n < `URX_DBITS_MIN) begin
                clamp_bits = `URX_DBITS_MIN;
            end else if (n > `URX_DBITS_MAX) begin
                clamp_bits = `URX_DBITS_MAX;
            end else begin
                clamp_bits = n;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    wire rx_sync;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [4:0] phase_ff;
    reg [4:0] nxt_phase;
    reg [2:0] votes_ff;
    reg [2:0] nxt_votes;
    reg [3:0] bitcnt_ff;
    reg [3:0] nxt_bitcnt;
    reg [9:0] shift_ff;
    reg [9:0] nxt_shift;
    reg [3:0] nbits_ff;
    reg [3:0] nxt_nbits;
    reg prev_ff;
    reg [9:0] nxt_data;
    reg nxt_fe;
    reg nxt_valid;
    reg bit_vote;

    // Synchronise the line before any logic looks at it.
    urx_sync u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .din(rx_serial),
        .dout(rx_sync)
    );

    // Mode-dependent sample positions; sample numbers equal phase plus one.
    wire [4:0] spb = double_speed_select ? `URX_SPB_DOUBLE : `URX_SPB_NORMAL;
    wire [4:0] vfirst = double_speed_select ? `URX_VOTE_FIRST_DOUBLE
                                            : `URX_VOTE_FIRST_NORMAL;
    wire [4:0] samp_no = phase_ff + 5'h01;
    wire in_window = (samp_no >= vfirst) && (samp_no <= vfirst + 5'h02);
    wire last_vote = (samp_no == vfirst + 5'h02);
    wire fall = prev_ff & ~rx_sync;

    assign rx_busy = (state_ff != `URX_ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // How a frame walks through the sequencer.
    // The phase counter runs from zero up to the samples-per-bit count less
    // one, and the sample number inside a bit is always the phase plus one.
    // In the idle state the tick that shows the first low sample is sample
    // one of the start bit, so the phase is loaded with one for the next tick.
    // The three centre samples are shifted into a small vote register; the
    // last of them is stored too, but is voted directly with the two before it.
    // A start bit that votes high is dropped at its last centre sample, and
    // the search for an edge resumes at once.
    // A start bit that votes low runs to its last sample, and the data state
    // begins on the following tick, aligned to this start bit alone.
    // Every data bit is voted at its last centre sample and shifted in from
    // the top, so the first bit on the line ends up in bit zero after the
    // final right shift by the unused width.
    // After the last data bit the stop state votes the first stop bit and
    // returns to idle at once, which in normal mode lets a new start be seen straight after.
    // Any second stop bit is simply idle line time to this logic.
    // Limitation: the speed mode must not change while a frame is in flight,
    // since it steers the counter; the frame width is latched at the start edge.
    // Trade-off: one phase counter serves all bit kinds, which saves area
    // but means the start bit runs its full length before data begins.
    ////////////////////////////////////////////////////////////////////////
    // Sequencer: one state per sample inside each bit.
    always @* begin
        nxt_state = state_ff;
        nxt_phase = phase_ff;
        nxt_votes = votes_ff;
        nxt_bitcnt = bitcnt_ff;
        nxt_shift = shift_ff;
        nxt_nbits = nbits_ff;
        nxt_data = rx_data_ff;
        nxt_fe = frame_error_flag_ff;
        nxt_valid = 1'b0;
        bit_vote = maj3({rx_sync, votes_ff[1:0]});
        if (sample_tick) begin
            case (state_ff)
                `URX_ST_IDLE: begin
                    // The first low sample is sample one, so phase starts at one next.
                    if (fall) begin
                        nxt_state = `URX_ST_START;
                        nxt_phase = 5'h01;
                        nxt_votes = 3'h0;
                        nxt_nbits = clamp_bits(frame_bits);
                    end
                end
                default: begin
                    if (in_window) begin
                        nxt_votes = {votes_ff[1:0], rx_sync};
                    end
                    nxt_phase = (phase_ff == spb - 5'h01) ? 5'h00 : phase_ff + 5'h01;
                    if (last_vote) begin
                        case (state_ff)
                            `URX_ST_START: begin
                                // Noise spikes go back to searching for an edge.
                                if (bit_vote) begin
                                    nxt_state = `URX_ST_IDLE;
                                end
                            end
                            `URX_ST_DATA: begin
                                nxt_shift = {bit_vote, shift_ff[9:1]};
                                nxt_bitcnt = bitcnt_ff + 4'h1;
                            end
                            default: begin
                                // Only the first stop bit is looked at; the line may
                                // start the next frame right after this sample in normal mode.
                                nxt_state = `URX_ST_IDLE;
                                nxt_fe = ~bit_vote;
                                nxt_data = shift_ff >> (4'h0a - nbits_ff);
                                nxt_valid = 1'b1;
                            end
                        endcase
                    end
                    // Bit boundaries advance the frame position; the start realigns here.
                    if (phase_ff == spb - 5'h01) begin
                        if (state_ff == `URX_ST_START) begin
                            nxt_state = `URX_ST_DATA;
                            nxt_bitcnt = 4'h0;
                        end else if (state_ff == `URX_ST_DATA && bitcnt_ff == nbits_ff) begin
                            nxt_state = `URX_ST_STOP;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers; previous sample tracks the line only on ticks.
    // In normal mode the last stop vote sample itself is the high half of
    // the next edge, so a low on the very next tick starts a frame.
    // In double speed the edge detector needs one fresh high sample after
    // the stop vote, so the earliest accepted start comes later there.
    // A start always needs a real high-to-low change: a line that stays
    // low through a bad stop bit must not start a frame by itself.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= `URX_ST_IDLE;
            phase_ff <= 5'h00;
            votes_ff <= 3'h0;
            bitcnt_ff <= 4'h0;
            shift_ff <= 10'h000;
            nbits_ff <= `URX_DBITS_MIN;
            prev_ff <= 1'b1;
            rx_data_ff <= 10'h000;
            frame_error_flag_ff <= 1'b0;
            rx_valid_ff <= 1'b0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            votes_ff <= nxt_votes;
            bitcnt_ff <= nxt_bitcnt;
            shift_ff <= nxt_shift;
            nbits_ff <= nxt_nbits;
            if (sample_tick) begin
                // Double speed forgets the stop vote sample to delay the next start.
                prev_ff <= (state_ff == `URX_ST_STOP && last_vote && double_speed_select)
                           ? 1'b0 : rx_sync;
            end
            rx_data_ff <= nxt_data;
            frame_error_flag_ff <= nxt_fe;
            rx_valid_ff <= nxt_valid;
        end
    end
endmodule // urx_recovery

`default_nettype wire

// file: urx_tx_model.sv
`timescale 1ns/100ps
`default_nettype none
// Remote transmitter; the line rests high between frames.
module urx_tx_model (
    input wire logic mclk,
    input wire logic sample_tick,
    output logic rx_serial
);
    initial rx_serial = 1'b1;
    // Bit times are whole tick counts, so the rate error is zero.
    task automatic tk(input int n);
        repeat (n) @(posedge mclk iff sample_tick);
    endtask
    // Start, n bits first bit first, then stop for sl ticks; g flips one centre sample of bit 0.
    task automatic send(input logic [9:0] d, input int n, spb, input logic stp, g, input int sl);
        rx_serial <= 1'b0;
        tk(spb);
        for (int i = 0; i < n; i++) begin
            rx_serial <= d[i];
            tk(g && i == 0 ? spb / 2 : spb);
            if (g && i == 0) begin
                rx_serial <= ~d[0];
                tk(1);
                rx_serial <= d[0];
                tk(spb / 2 - 1);
            end
        end
        rx_serial <= stp;
        tk(sl);
        // A good stop already leaves the line high; a bad one is released here.
        if (!stp)
            rx_serial <= 1'b1;
    endtask
endmodule // urx_tx_model
`default_nettype wire

// file: urx_recovery_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks; all in the one clock domain.
module urx_recovery_properties (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sample_tick,
    input wire logic double_speed_select,
    input wire logic [3:0] frame_bits,
    input wire logic [9:0] rx_data_ff,
    input wire logic frame_error_flag_ff,
    input wire logic rx_valid_ff,
    input wire logic rx_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    valid_on_tick_a: assert property (rx_valid_ff |-> $past(sample_tick))
        else $error("frame end not one cycle after a tick");
    valid_ends_busy_a: assert property (rx_valid_ff |-> !rx_busy && $past(rx_busy))
        else $error("frame end while still busy");
    busy_on_tick_a: assert property ($rose(rx_busy) |-> $past(sample_tick))
        else $error("start taken off a tick");
    start_hold_a: assert property ($rose(rx_busy) && !double_speed_select |-> rx_busy[*8])
        else $error("start dropped before its validation samples");
    data_hold_a: assert property (!rx_valid_ff |-> $stable(rx_data_ff))
        else $error("data changed outside a frame end");
    flag_hold_a: assert property (!rx_valid_ff |-> $stable(frame_error_flag_ff))
        else $error("frame error changed outside a frame end");
    short_width_a: assert property (rx_valid_ff && frame_bits == 4'h5 |-> rx_data_ff[9:5] == 5'h00)
        else $error("bits beyond the frame width set");
    valid_pulse_a: assert property (rx_valid_ff |=> !rx_valid_ff)
        else $error("frame end longer than one cycle");
endmodule // urx_recovery_properties
bind urx_recovery urx_recovery_properties urx_recovery_properties_i (.mclk(mclk), .reset_n(reset_n),
    .sample_tick(sample_tick), .double_speed_select(double_speed_select), .frame_bits(frame_bits),
    .rx_data_ff(rx_data_ff), .frame_error_flag_ff(frame_error_flag_ff), .rx_valid_ff(rx_valid_ff),
    .rx_busy(rx_busy));
`default_nettype wire

// file: urx_recovery_test.sv
`timescale 1ns/100ps
`default_nettype none
module urx_recovery_test;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic sample_tick = 1'b0;
    logic double_speed_select = 1'b0;
    logic [3:0] frame_bits = 4'h8;
    logic [1:0] div_ff = 2'h0;
    wire rx_serial;
    wire [9:0] rx_data_ff;
    wire frame_error_flag_ff;
    wire rx_valid_ff;
    wire rx_busy;
    int failures = 0;
    int comparisons = 0;
    always #20 mclk = ~mclk;
    // A tick every fourth clock keeps each tick clear of the two-clock synchroniser lag.
    always @(posedge mclk) begin
        div_ff <= div_ff + 2'h1;
        sample_tick <= (div_ff == 2'h3);
    end
    urx_recovery urx_recovery_i (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
        .rx_serial(rx_serial), .sample_tick(sample_tick), .double_speed_select(double_speed_select),
        .frame_bits(frame_bits), .rx_data_ff(rx_data_ff), .frame_error_flag_ff(frame_error_flag_ff),
        .rx_valid_ff(rx_valid_ff), .rx_busy(rx_busy));
    urx_tx_model urx_tx_model_i (.mclk(mclk), .sample_tick(sample_tick), .rx_serial(rx_serial));
    ////////////////////////////////////////
    task automatic chk(input logic [9:0] g, e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Waits past the current cycle for the next frame end, then judges it.
    task automatic expect_frame(input logic [9:0] d, input logic fe);
        int k;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (rx_valid_ff !== 1'b1 && k < 3000);
        chk({9'h0, rx_valid_ff}, 10'h1);
        chk(rx_data_ff, d);
        chk({9'h0, frame_error_flag_ff}, {9'h0, fe});
    endtask
    task automatic frame(input logic [9:0] d, input int n, spb, input logic stp, g, fe);
        urx_tx_model_i.tk(1);
        fork
            urx_tx_model_i.send(d, n, spb, stp, g, spb);
            expect_frame(d, fe);
        join
    endtask
    task automatic t_noise;
        logic [9:0] n;
        n = 10'h0;
        urx_tx_model_i.tk(1);
        urx_tx_model_i.send(10'h0, 0, 4, 1'b1, 1'b0, 1);
        repeat (400) begin
            @(negedge mclk);
            n = n + {9'h0, rx_valid_ff === 1'b1};
        end
        chk(n, 10'h0);
        $display("test noise done");
    endtask
    task automatic t_back_to_back;
        @(posedge mclk);
        frame_bits <= 4'h5;
        urx_tx_model_i.tk(1);
        fork
            begin
                urx_tx_model_i.send(10'h015, 5, 16, 1'b1, 1'b0, 10);
                urx_tx_model_i.send(10'h00a, 5, 16, 1'b1, 1'b0, 16);
            end
            begin
                expect_frame(10'h015, 1'b0);
                expect_frame(10'h00a, 1'b0);
            end
        join
        $display("test back to back done");
    endtask
    task automatic t_double;
        @(posedge mclk);
        double_speed_select <= 1'b1;
        frame_bits <= 4'ha;
        frame(10'h2c3, 10, 8, 1'b1, 1'b0, 1'b0);
        frame(10'h13c, 10, 8, 1'b1, 1'b1, 1'b0);
        $display("test double speed done");
    endtask
    task automatic test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        t_noise();
        frame(10'h0a5, 8, 16, 1'b1, 1'b0, 1'b0);
        $display("test normal done");
        frame(10'h03c, 8, 16, 1'b0, 1'b0, 1'b1);
        $display("test frame error done");
        frame(10'h0a4, 8, 16, 1'b1, 1'b1, 1'b0);
        $display("test vote done");
        t_back_to_back();
        t_double();
        test_done();
    end
    // The tests need about 4000 clocks; this limit is ten times that.
    initial begin
        #1600000;
        failures++;
        $display("MISMATCH t=%0t got %h exp %h", $time, 1'b0, 1'b1);
        test_done();
    end
endmodule // urx_recovery_test
`default_nettype wire
